// *** design/cdr_alu_if.sv ***
// operand and flag bundle between register file and flag unit
`timescale 1ns/1ps
interface cdr_alu_if;
    import cdr_pkg::*;
    logic [7:0] opa;
    logic [7:0] opb;
    cdr_op_t    op;
    logic [7:0] res;
    logic       fh;
    logic       fn;
    logic       fz;
    logic       fv;
    logic       fc;

    modport regs (output opa, output opb, output op, input res, input fh, input fn, input fz, input fv, input fc);
    modport unit (input opa, input opb, input op, output res, output fh, output fn, output fz, output fv, output fc);
endinterface : cdr_alu_if

// *** design/cdr_flag_unit.sv ***
// 8-bit result and condition flag computation
`timescale 1ns/1ps
`include "cdr_params.svh"
module cdr_flag_unit
    import cdr_pkg::*;
(
    cdr_alu_if.unit alu
);
    logic [8:0] sum9;
    logic [8:0] dif9;
    logic [4:0] hsum;
    logic [4:0] hdif;

    // widened sums keep carry and borrow out of bit 7 and bit 3
    assign sum9 = {1'b0, alu.opa} + {1'b0, alu.opb};
    assign dif9 = {1'b0, alu.opa} - {1'b0, alu.opb};
    assign hsum = {1'b0, alu.opa[`CDR_NIB_MSB:0]} + {1'b0, alu.opb[`CDR_NIB_MSB:0]};
    assign hdif = {1'b0, alu.opa[`CDR_NIB_MSB:0]} - {1'b0, alu.opb[`CDR_NIB_MSB:0]};

    // per-operation result, half carry, overflow and carry
    always_comb
    begin
        case (alu.op)
            CDR_OP_ADD:
            begin
                alu.res = sum9[7:0];
                alu.fh  = hsum[4];
                alu.fv  = (alu.opa[7] == alu.opb[7]) && (sum9[7] != alu.opa[7]);
                alu.fc  = sum9[8];
            end
            CDR_OP_SUB:
            begin
                alu.res = dif9[7:0];
                alu.fh  = hdif[4];
                alu.fv  = (alu.opa[7] != alu.opb[7]) && (dif9[7] != alu.opa[7]);
                alu.fc  = dif9[8];
            end
            CDR_OP_SHL:
            begin
                alu.res = {alu.opa[6:0], 1'b0};
                alu.fh  = 1'b0;
                alu.fv  = 1'b0;
                alu.fc  = alu.opa[7];
            end
            default:
            begin
                alu.res = {1'b0, alu.opa[7:1]};
                alu.fh  = 1'b0;
                alu.fv  = 1'b0;
                alu.fc  = alu.opa[0];
            end
        endcase
    end

    // sign and zero follow the result
    assign alu.fn = alu.res[`CDR_BYTE_MSB];
    assign alu.fz = (alu.res == 8'h00);
endmodule : cdr_flag_unit

// *** design/cdr_irq_gpr.sv ***
// interrupt acceptance and register-bank address forming
`timescale 1ns/1ps
`include "cdr_params.svh"
module cdr_irq_gpr
    import cdr_pkg::*;
(
    input  wire logic       ie_i,
    input  wire logic [1:0] mask_i,
    input  wire logic       req_i,
    input  wire logic [1:0] req_lvl_i,
    input  wire logic [7:0] bank_i,
    input  wire logic [2:0] rnum_i,
    output logic            accept_o,
    output logic [15:0]     gpr_addr_o
);
    // smaller level number means higher priority
    assign accept_o = req_i && ie_i && (cdr_level(req_lvl_i) < cdr_level(mask_i));

    // eight registers per bank, 32 banks above the data-area base
    assign gpr_addr_o = `CDR_GPR_BASE + {8'h00, bank_i[`CDR_BANK_MSB:0], rnum_i};
endmodule : cdr_irq_gpr

// *** design/cdr_params.svh ***
// constants for the dedicated cpu register block
`ifndef CDR_PARAMS_SVH
`define CDR_PARAMS_SVH

// apb byte offsets
`define CDR_OFF_PC      8'h00
`define CDR_OFF_ACC     8'h04
`define CDR_OFF_TMP     8'h08
`define CDR_OFF_IDX     8'h0c
`define CDR_OFF_EXT     8'h10
`define CDR_OFF_STK     8'h14
`define CDR_OFF_PSW     8'h18
`define CDR_OFF_GPR     8'h1c
`define CDR_OFF_STAT    8'h20

// reset values
`define CDR_PC_RST      16'hfffd
`define CDR_IE_RST      1'b0
`define CDR_IL_RST      2'b11

// cond_flags bit positions (low byte of proc_state_word)
`define CDR_BIT_C       0
`define CDR_BIT_V       1
`define CDR_BIT_Z       2
`define CDR_BIT_N       3
`define CDR_BIT_ILLO    4
`define CDR_BIT_ILHI    5
`define CDR_BIT_IE      6
`define CDR_BIT_H       7

// field widths and positions
`define CDR_BANK_MSB    4
`define CDR_RSEL_W      3
`define CDR_GPR_BASE    16'h0100
`define CDR_BYTE_MSB    7
`define CDR_NIB_MSB     3

`endif

// *** design/cdr_pkg.sv ***
// types shared by the dedicated cpu register block
package cdr_pkg;

    // target of a core-side write
    typedef enum logic [2:0] {
        CDR_SEL_PC,
        CDR_SEL_ACC,
        CDR_SEL_TMP,
        CDR_SEL_IDX,
        CDR_SEL_EXT,
        CDR_SEL_STK,
        CDR_SEL_PSW
    } cdr_sel_t;

    // flag-producing operations
    typedef enum logic [1:0] {
        CDR_OP_ADD,
        CDR_OP_SUB,
        CDR_OP_SHL,
        CDR_OP_SHR
    } cdr_op_t;

    // interrupt level number: 1 highest, 3 lowest
    function automatic logic [1:0] cdr_level(input logic [1:0] code);
        cdr_level = (code[1] == 1'b0) ? 2'd1 : ((code[0] == 1'b0) ? 2'd2 : 2'd3);
    endfunction : cdr_level

endpackage : cdr_pkg

// *** design/cdr_regs.sv ***
// dedicated cpu register set with apb access and core port
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "cdr_params.svh"

// Overview of operation
// - the fetch pointer is 16 bits and reset loads it with fffd hex.
// - the first operand register is 16 bits, byte operations use its low byte, reset leaves it undefined.
// - the second operand register is 16 bits, byte operations use its low byte, reset leaves it undefined.
// - offset base, extra pointer and stack top are 16-bit address registers left undefined by reset.
// - the state word splits into bank select in the upper byte and condition flags in the lower byte.
// - reset clears the interrupt enable and sets both mask bits to 11, other state bits stay undefined.
// - interrupts are accepted only while the interrupt enable is 1.
// - mask codes 00/01 mean level 1, 10 level 2, 11 level 3, and only higher-priority requests pass.
// - half carry is set on carry or borrow from bit 3 into bit 4, else cleared.
// - negative copies the most significant bit of the result.
// - zero is set for a zero result and cleared otherwise.
// - overflow is set on two's complement overflow and cleared otherwise.
// - carry is set on carry or borrow out of bit 7, or takes the shifted-out bit for shifts.
// - general registers are 8 bits, eight per bank, up to 32 banks chosen by bank select.
module cdr_regs
    import cdr_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // core execution side
    input  wire logic        core_we_i,
    input  wire cdr_sel_t    core_sel_i,
    input  wire logic [15:0] core_wdata_i,
    input  wire logic        core_pc_inc_i,
    input  wire logic        alu_upd_i,
    input  wire cdr_op_t     alu_op_i,
    input  wire logic [2:0]  gpr_num_i,
    input  wire logic        irq_req_i,
    input  wire logic [1:0]  irq_lvl_i,
    output logic      [15:0] fetch_pointer_o,
    output logic      [15:0] first_operand_o,
    output logic      [15:0] second_operand_o,
    output logic      [15:0] offset_base_o,
    output logic      [15:0] extra_mem_ptr_o,
    output logic      [15:0] stack_top_o,
    output logic      [15:0] proc_state_word_o,
    output logic      [15:0] gpr_addr_o,
    output logic             irq_accept_o
);
    ////////////////////////////////////////////////////////////////////////////
    logic [15:0] fetch_pointer_q;
    logic [15:0] acc_q;
    logic [15:0] tmp_q;
    logic [15:0] idx_q;
    logic [15:0] ext_q;
    logic [15:0] stk_q;
    logic [7:0]  bank_select_q;
    logic [7:0]  cond_flags_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [15:0] gpr_addr_q;
    logic        irq_accept_q;
    logic        apb_wr;
    logic        apb_hit;
    logic [31:0] rd_mux;
    logic        accept_d;
    logic [15:0] gpr_addr_d;

    // reset code of the level mask, split into its two bits below
    localparam logic [1:0] IL_RST = `CDR_IL_RST;

    cdr_alu_if alu_bus ();

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic core_hit(input logic we, input cdr_sel_t sel, input cdr_sel_t tgt);
        core_hit = we && (sel == tgt);
    endfunction : core_hit

    function automatic logic apb_hit_at(input logic wr, input logic [7:0] addr, input logic [7:0] off);
        apb_hit_at = wr && (addr == off);
    endfunction : apb_hit_at

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: one-cycle access phase, write commits at the pready edge
    assign apb_wr = psel_i && penable_i && pwrite_i && pready_q;

    // read mux and address decode
    always_comb
    begin
        apb_hit = 1'b1;
        rd_mux  = 32'h0000_0000;
        case (paddr_i)
            `CDR_OFF_PC:   rd_mux = {16'h0000, fetch_pointer_q};
            `CDR_OFF_ACC:  rd_mux = {16'h0000, acc_q};
            `CDR_OFF_TMP:  rd_mux = {16'h0000, tmp_q};
            `CDR_OFF_IDX:  rd_mux = {16'h0000, idx_q};
            `CDR_OFF_EXT:  rd_mux = {16'h0000, ext_q};
            `CDR_OFF_STK:  rd_mux = {16'h0000, stk_q};
            `CDR_OFF_PSW:  rd_mux = {16'h0000, bank_select_q, cond_flags_q};
            `CDR_OFF_GPR:  rd_mux = {16'h0000, gpr_addr_q};
            `CDR_OFF_STAT: rd_mux = {31'h0000_0000, irq_accept_q};
            default:       apb_hit = 1'b0;
        endcase
    end

    // answer handshake: ready raised for the single access cycle
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            pready_q  <= psel_i && !penable_i;
            pslverr_q <= psel_i && !penable_i && !apb_hit; // unmapped offsets fail
            prdata_q  <= (psel_i && !penable_i && !pwrite_i) ? rd_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fetch pointer; core writes win over apb in the same cycle
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            fetch_pointer_q <= `CDR_PC_RST;
        else if (ce_i)
        begin
            if (core_hit(core_we_i, core_sel_i, CDR_SEL_PC))
                fetch_pointer_q <= core_wdata_i;
            else if (apb_hit_at(apb_wr, paddr_i, `CDR_OFF_PC))
                fetch_pointer_q <= pwdata_i[15:0];
            else if (core_pc_inc_i)
                fetch_pointer_q <= fetch_pointer_q + 16'h0001;
        end
    end

    // operand registers: no reset, contents undefined until written
    always_ff @(posedge clk_sys_i)
    begin
        if (ce_i)
        begin
            if (alu_upd_i)
                acc_q[`CDR_BYTE_MSB:0] <= alu_bus.res;
            else if (core_hit(core_we_i, core_sel_i, CDR_SEL_ACC))
                acc_q <= core_wdata_i;
            else if (apb_hit_at(apb_wr, paddr_i, `CDR_OFF_ACC))
                acc_q <= pwdata_i[15:0];
            if (core_hit(core_we_i, core_sel_i, CDR_SEL_TMP))
                tmp_q <= core_wdata_i;
            else if (apb_hit_at(apb_wr, paddr_i, `CDR_OFF_TMP))
                tmp_q <= pwdata_i[15:0];
        end
    end

    // address registers: no reset
    always_ff @(posedge clk_sys_i)
    begin
        if (ce_i)
        begin
            if (core_hit(core_we_i, core_sel_i, CDR_SEL_IDX))
                idx_q <= core_wdata_i;
            else if (apb_hit_at(apb_wr, paddr_i, `CDR_OFF_IDX))
                idx_q <= pwdata_i[15:0];
            if (core_hit(core_we_i, core_sel_i, CDR_SEL_EXT))
                ext_q <= core_wdata_i;
            else if (apb_hit_at(apb_wr, paddr_i, `CDR_OFF_EXT))
                ext_q <= pwdata_i[15:0];
            if (core_hit(core_we_i, core_sel_i, CDR_SEL_STK))
                stk_q <= core_wdata_i;
            else if (apb_hit_at(apb_wr, paddr_i, `CDR_OFF_STK))
                stk_q <= pwdata_i[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flag unit sees the low bytes of the two operand registers
    assign alu_bus.opa = acc_q[`CDR_BYTE_MSB:0];
    assign alu_bus.opb = tmp_q[`CDR_BYTE_MSB:0];
    assign alu_bus.op  = alu_op_i;

    cdr_flag_unit u_flags (
        .alu (alu_bus.unit)
    );

    // bank select: upper byte of the state word, no reset
    always_ff @(posedge clk_sys_i)
    begin
        if (ce_i)
        begin
            if (core_hit(core_we_i, core_sel_i, CDR_SEL_PSW))
                bank_select_q <= core_wdata_i[15:8];
            else if (apb_hit_at(apb_wr, paddr_i, `CDR_OFF_PSW))
                bank_select_q <= pwdata_i[15:8];
        end
    end

    // control bits of cond_flags: enable and level mask have reset values
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            cond_flags_q[`CDR_BIT_IE]   <= `CDR_IE_RST;
            cond_flags_q[`CDR_BIT_ILHI] <= IL_RST[1];
            cond_flags_q[`CDR_BIT_ILLO] <= IL_RST[0];
        end
        else if (ce_i)
        begin
            if (core_hit(core_we_i, core_sel_i, CDR_SEL_PSW))
            begin
                cond_flags_q[`CDR_BIT_IE]   <= core_wdata_i[`CDR_BIT_IE];
                cond_flags_q[`CDR_BIT_ILHI] <= core_wdata_i[`CDR_BIT_ILHI];
                cond_flags_q[`CDR_BIT_ILLO] <= core_wdata_i[`CDR_BIT_ILLO];
            end
            else if (apb_hit_at(apb_wr, paddr_i, `CDR_OFF_PSW))
            begin
                cond_flags_q[`CDR_BIT_IE]   <= pwdata_i[`CDR_BIT_IE];
                cond_flags_q[`CDR_BIT_ILHI] <= pwdata_i[`CDR_BIT_ILHI];
                cond_flags_q[`CDR_BIT_ILLO] <= pwdata_i[`CDR_BIT_ILLO];
            end
            // arithmetic flags: left undefined by reset; alu update wins over writes
            if (alu_upd_i)
            begin
                cond_flags_q[`CDR_BIT_H] <= alu_bus.fh;
                cond_flags_q[`CDR_BIT_N] <= alu_bus.fn;
                cond_flags_q[`CDR_BIT_Z] <= alu_bus.fz;
                cond_flags_q[`CDR_BIT_V] <= alu_bus.fv;
                cond_flags_q[`CDR_BIT_C] <= alu_bus.fc;
            end
            else if (core_hit(core_we_i, core_sel_i, CDR_SEL_PSW))
            begin
                cond_flags_q[`CDR_BIT_H] <= core_wdata_i[`CDR_BIT_H];
                cond_flags_q[`CDR_BIT_N] <= core_wdata_i[`CDR_BIT_N];
                cond_flags_q[`CDR_BIT_Z] <= core_wdata_i[`CDR_BIT_Z];
                cond_flags_q[`CDR_BIT_V] <= core_wdata_i[`CDR_BIT_V];
                cond_flags_q[`CDR_BIT_C] <= core_wdata_i[`CDR_BIT_C];
            end
            else if (apb_hit_at(apb_wr, paddr_i, `CDR_OFF_PSW))
            begin
                cond_flags_q[`CDR_BIT_H] <= pwdata_i[`CDR_BIT_H];
                cond_flags_q[`CDR_BIT_N] <= pwdata_i[`CDR_BIT_N];
                cond_flags_q[`CDR_BIT_Z] <= pwdata_i[`CDR_BIT_Z];
                cond_flags_q[`CDR_BIT_V] <= pwdata_i[`CDR_BIT_V];
                cond_flags_q[`CDR_BIT_C] <= pwdata_i[`CDR_BIT_C];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt gate and bank address
    cdr_irq_gpr u_irq_gpr (
        .ie_i       (cond_flags_q[`CDR_BIT_IE]),
        .mask_i     ({cond_flags_q[`CDR_BIT_ILHI], cond_flags_q[`CDR_BIT_ILLO]}),
        .req_i      (irq_req_i),
        .req_lvl_i  (irq_lvl_i),
        .bank_i     (bank_select_q),
        .rnum_i     (gpr_num_i),
        .accept_o   (accept_d),
        .gpr_addr_o (gpr_addr_d)
    );

    // registered so every top output comes from a flop; one cycle of latency
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            irq_accept_q <= 1'b0;
            gpr_addr_q   <= 16'h0000;
        end
        else if (ce_i)
        begin
            irq_accept_q <= accept_d;
            gpr_addr_q   <= gpr_addr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign prdata_o          = prdata_q;
    assign pready_o          = pready_q;
    assign pslverr_o         = pslverr_q;
    assign fetch_pointer_o   = fetch_pointer_q;
    assign first_operand_o   = acc_q;
    assign second_operand_o  = tmp_q;
    assign offset_base_o     = idx_q;
    assign extra_mem_ptr_o   = ext_q;
    assign stack_top_o       = stk_q;
    assign proc_state_word_o = {bank_select_q, cond_flags_q};
    assign gpr_addr_o        = gpr_addr_q;
    assign irq_accept_o      = irq_accept_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_setup;
        psel_i && !penable_i && ce_i;
    endsequence

    property p_pc_reset;
        $rose(rst_n_i) |-> fetch_pointer_q == `CDR_PC_RST;
    endproperty
    a_pc_reset: assert property (@(posedge clk_sys_i) p_pc_reset) else $error("pc not fffd after reset");

    property p_psw_reset;
        $rose(rst_n_i) |-> proc_state_word_o[6:4] == 3'b011;
    endproperty
    a_psw_reset: assert property (@(posedge clk_sys_i) p_psw_reset) else $error("ie/mask reset wrong");

    property p_irq_blocked;
        ce_i && !cond_flags_q[`CDR_BIT_IE] |=> !irq_accept_q;
    endproperty
    a_irq_blocked: assert property (p_irq_blocked) else $error("irq accepted while disabled");

    property p_irq_level;
        ce_i && irq_req_i && cond_flags_q[`CDR_BIT_IE] && cond_flags_q[5:4] == 2'b11
            && irq_lvl_i[1] == 1'b0 |=> irq_accept_q;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("level 1 request refused by mask 3");

    property p_mask_lvl1;
        ce_i && cond_flags_q[5] == 1'b0 |=> !irq_accept_q;
    endproperty
    a_mask_lvl1: assert property (p_mask_lvl1) else $error("request passed level 1 mask");

    property p_zero_flag;
        ce_i && alu_upd_i |=> cond_flags_q[`CDR_BIT_Z] == (acc_q[7:0] == 8'h00);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag disagrees with result");

    property p_neg_flag;
        ce_i && alu_upd_i |=> cond_flags_q[`CDR_BIT_N] == acc_q[7];
    endproperty
    a_neg_flag: assert property (p_neg_flag) else $error("negative flag disagrees with msb");

    property p_carry_add;
        ce_i && alu_upd_i && alu_op_i == CDR_OP_ADD |=>
            cond_flags_q[`CDR_BIT_C] == ({1'b0, $past(acc_q[7:0])} + {1'b0, $past(tmp_q[7:0])} > 9'h0ff);
    endproperty
    a_carry_add: assert property (p_carry_add) else $error("add carry wrong");

    property p_half_add;
        ce_i && alu_upd_i && alu_op_i == CDR_OP_ADD |=>
            cond_flags_q[`CDR_BIT_H] == ({1'b0, $past(acc_q[3:0])} + {1'b0, $past(tmp_q[3:0])} > 5'h0f);
    endproperty
    a_half_add: assert property (p_half_add) else $error("half carry wrong");

    property p_apb_answer;
        s_setup |=> pready_q ##1 !pready_q || !ce_i;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb ready not one cycle after setup");

    // the bank pointer has no reset, so its address check waits for the first state-word write
    logic bank_set_q;
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            bank_set_q <= 1'b0;
        else if (ce_i && (core_hit(core_we_i, core_sel_i, CDR_SEL_PSW)
                          || apb_hit_at(apb_wr, paddr_i, `CDR_OFF_PSW)))
            bank_set_q <= 1'b1;
    end

    property p_gpr_addr;
        ce_i && bank_set_q |=>
            gpr_addr_q == `CDR_GPR_BASE + {8'h00, $past(bank_select_q[`CDR_BANK_MSB:0]), $past(gpr_num_i)};
    endproperty
    a_gpr_addr: assert property (p_gpr_addr) else $error("bank address wrong");
endmodule : cdr_regs

// *** testbench/cdr_regs_tb.sv ***
// self-checking bench for the dedicated cpu register block
`timescale 1ns/1ps
module cpu_dedicated_registers_ccr_test
    import cdr_pkg::*;
;
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        ce_i = 1'b1;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic        pready_o, pslverr_o, err, irq_accept_o;
    logic        core_we_i = 1'b0, core_pc_inc_i = 1'b0, alu_upd_i = 1'b0, irq_req_i = 1'b0;
    cdr_sel_t    core_sel_i = CDR_SEL_ACC;
    cdr_op_t     alu_op_i = CDR_OP_ADD;
    logic [15:0] core_wdata_i = 16'h0;
    logic [2:0]  gpr_num_i = 3'h0;
    logic [1:0]  irq_lvl_i = 2'h0;
    logic [15:0] fetch_pointer_o, first_operand_o, second_operand_o, offset_base_o;
    logic [15:0] extra_mem_ptr_o, stack_top_o, proc_state_word_o, gpr_addr_o;
    int          err_total = 0;
    int          checks = 0;

    cdr_regs uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .core_we_i(core_we_i),
        .core_sel_i(core_sel_i), .core_wdata_i(core_wdata_i), .core_pc_inc_i(core_pc_inc_i),
        .alu_upd_i(alu_upd_i), .alu_op_i(alu_op_i), .gpr_num_i(gpr_num_i), .irq_req_i(irq_req_i),
        .irq_lvl_i(irq_lvl_i), .fetch_pointer_o(fetch_pointer_o), .first_operand_o(first_operand_o),
        .second_operand_o(second_operand_o), .offset_base_o(offset_base_o),
        .extra_mem_ptr_o(extra_mem_ptr_o), .stack_top_o(stack_top_o),
        .proc_state_word_o(proc_state_word_o), .gpr_addr_o(gpr_addr_o), .irq_accept_o(irq_accept_o));

    ////////////////////////////////////////////////////////////////////////////////
    // 50 mhz clock
    initial
    begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // apb master; waits for pready under a bound, never assumes latency
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_i);
        psel_i <= 1'b1; pwrite_i <= wr; paddr_i <= a; pwdata_i <= d; penable_i <= 1'b0;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk_sys_i);
            if (pready_o === 1'b1)
                break;
        end
        if (n == 20)
        begin
            err_total++;
            end_sim();
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic core(input cdr_sel_t s, input logic [15:0] d);
        @(posedge clk_sys_i);
        core_we_i <= 1'b1; core_sel_i <= s; core_wdata_i <= d;
        @(posedge clk_sys_i);
        core_we_i <= 1'b0;
    endtask : core

    // one flag-unit case: operands through the core port, then one update pulse
    task automatic alu(input cdr_op_t op, input logic [7:0] a, input logic [7:0] b,
                       input logic [7:0] res, input logic [4:0] fl);
        core(CDR_SEL_ACC, {8'h00, a});
        core(CDR_SEL_TMP, {8'h00, b});
        @(posedge clk_sys_i);
        alu_upd_i <= 1'b1; alu_op_i <= op;
        @(posedge clk_sys_i);
        alu_upd_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(32'(first_operand_o[7:0]), 32'(res));
        chk(32'({proc_state_word_o[7], proc_state_word_o[3:0]}), 32'(fl));
    endtask : alu

    function automatic int lvl(input logic [1:0] c);
        return c[1] ? (c[0] ? 3 : 2) : 1;
    endfunction : lvl

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        @(negedge clk_sys_i);
        chk(32'(fetch_pointer_o), 32'h0000fffd);
        chk(32'(proc_state_word_o[6:4]), 32'h3);
        @(posedge clk_sys_i);
        core_pc_inc_i <= 1'b1;
        @(posedge clk_sys_i);
        core_pc_inc_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(32'(fetch_pointer_o), 32'h0000fffe);
        $display("reset test done");
    endtask : t_reset

    // the six registers from fetch pointer to stack top over apb, upper half reads zero, plus an unmapped hole
    task automatic t_apb;
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, 8'(4 * i), {16'hffff, 16'(16'h1111 * (i + 1))});
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(rd, {16'h0000, 16'(16'h1111 * (i + 1))});
        end
        chk(32'(offset_base_o), 32'h00004444);
        chk({second_operand_o, stack_top_o}, 32'h33336666);
        chk(32'(extra_mem_ptr_o), 32'h00005555);
        apb(1'b0, 8'h24, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        $display("apb test done");
    endtask : t_apb

    task automatic t_bank;
        apb(1'b1, 8'h18, 32'h00003540);
        gpr_num_i <= 3'h6;
        repeat (2) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk(32'(proc_state_word_o[15:8]), 32'h35);
        chk(32'(gpr_addr_o), 32'h000001ae);
        $display("bank test done");
    endtask : t_bank

    // every enable, mask code and request code
    task automatic t_irq;
        for (int e = 0; e < 2; e++)
            for (int m = 0; m < 4; m++)
            begin
                apb(1'b1, 8'h18, {24'h0, 1'b0, 1'(e), 2'(m), 4'h0});
                for (int r = 0; r < 4; r++)
                begin
                    @(posedge clk_sys_i);
                    irq_req_i <= 1'b1; irq_lvl_i <= 2'(r);
                    @(posedge clk_sys_i);
                    @(negedge clk_sys_i);
                    chk(32'(irq_accept_o), 32'((e == 1) && (lvl(2'(r)) < lvl(2'(m)))));
                end
            end
        irq_req_i <= 1'b0;
        $display("irq test done");
    endtask : t_irq

    task automatic t_flags;
        alu(CDR_OP_ADD, 8'h08, 8'h08, 8'h10, 5'b10000);
        alu(CDR_OP_ADD, 8'h7f, 8'h01, 8'h80, 5'b11010);
        alu(CDR_OP_ADD, 8'hff, 8'h01, 8'h00, 5'b10101);
        alu(CDR_OP_SUB, 8'h00, 8'h01, 8'hff, 5'b11001);
        alu(CDR_OP_SUB, 8'h80, 8'h01, 8'h7f, 5'b10010);
        alu(CDR_OP_SHL, 8'h81, 8'h00, 8'h02, 5'b00001);
        alu(CDR_OP_SHR, 8'h01, 8'h00, 8'h00, 5'b00101);
        $display("flag test done");
    endtask : t_flags

    // core port reaches fetch pointer, address registers and state word; a cycle with ce low must freeze the fetch pointer
    task automatic t_core;
        core(CDR_SEL_PC, 16'h1234);
        core(CDR_SEL_IDX, 16'h2345);
        core(CDR_SEL_EXT, 16'h3456);
        core(CDR_SEL_STK, 16'h4567);
        core(CDR_SEL_PSW, 16'h0a3c);
        @(negedge clk_sys_i);
        chk({fetch_pointer_o, offset_base_o}, 32'h12342345);
        chk({extra_mem_ptr_o, stack_top_o}, 32'h34564567);
        chk(32'(proc_state_word_o), 32'h00000a3c);
        @(posedge clk_sys_i);
        ce_i <= 1'b0;
        core_pc_inc_i <= 1'b1;
        @(posedge clk_sys_i);
        ce_i <= 1'b1;
        core_pc_inc_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(32'(fetch_pointer_o), 32'h00001234);
        $display("core test done");
    endtask : t_core

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence: reset held for 8 cycles, then each scenario
    initial
    begin
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_apb();
        t_bank();
        t_irq();
        t_flags();
        t_core();
        end_sim();
    end
endmodule : cpu_dedicated_registers_ccr_test
